// >>> src/mtc_pkg.sv
// package for the modulo timer: register offsets, field layout, reset values,
// prescaler and source encodings.
// assumes an 8-bit register port with byte-wide offsets as printed.
package mtc_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] MTC_STATUS_OFS = 8'h18; // status and control
  localparam logic [7:0] MTC_CLKCFG_OFS = 8'h19; // clock configuration
  localparam logic [7:0] MTC_COUNT_OFS = 8'h1a; // live count, read only
  localparam logic [7:0] MTC_LIMIT_OFS = 8'h1b; // wrap limit
  // status and control bit positions
  localparam int MTC_WRAP_BIT = 7;
  localparam int MTC_WIE_BIT = 6;
  localparam int MTC_CRST_BIT = 5;
  localparam int MTC_HALT_BIT = 4;
  // clock configuration field positions
  localparam int MTC_SRC_LSB = 4;
  localparam int MTC_DIV_LSB = 0;
  // reset values
  localparam logic [1:0] MTC_SRC_RST = 2'h0;
  localparam logic [3:0] MTC_DIV_RST = 4'h0;
  localparam logic [7:0] MTC_CNT_RST = 8'h00;
  localparam logic [7:0] MTC_LIM_RST = 8'h00;
  // largest defined divide select code, divide by 256
  localparam logic [3:0] MTC_DIV_MAX = 4'h8;
  localparam logic [7:0] MTC_ZERO8 = 8'h00;
  localparam logic [7:0] MTC_ONE8 = 8'h01;
  // counting source encodings
  typedef enum logic [1:0] {
    MTC_SRC_BUS = 2'b00,
    MTC_SRC_FIXED = 2'b01,
    MTC_SRC_FALL = 2'b10,
    MTC_SRC_RISE = 2'b11
  } mtc_src_t;
endpackage

// >>> src/mtc_timer.sv
// modulo timer core: source select, prescaler, 8-bit counter, wrap limit,
// wrap flag with two-step clear, halt bit and the register port.
// assumes the fixed clock tick is a one-cycle enable on ref_clk and the
// external pin is asynchronous, so it is synchronised here.
//
// Summary of operation
// - two bits choose bus, fixed, fall, rise
// - source change keeps count, continues counting
// - reset selects bus clock source
// - four bits pick divide by 1 to 256
// - undefined divide codes act as 256
// - divide change keeps count, new rate
// - reset selects undivided counting
// - config bits 7 and 6 read zero
// - count reads live, writes ignored
// - reset clears counter to zero
// - limit value wraps count, raises flag
// - zero limit means full free-run
// - limit write clears count and flag
// - reset clears limit to zero
// - wrap to zero after limit, set flag
// - flag clear needs read then write zero
// - halt holds count; reset sets halt
//
// hazards and limits worth knowing before reuse:
// the prescaler is never cleared, so the first period after a source or
// divide change may be shorter than the programmed one; this keeps the
// count running across changes at the price of one uneven period.
// the external pin is sampled on ref_clk, so edges closer than about four
// bus cycles apart may be merged or lost; the driver must respect that.
// the fixed clock arrives as a one-cycle enable on ref_clk, so it needs no
// synchroniser; a true second clock would need one in front of this core.
// a limit write wins over a wrap in the same cycle, a wrap wins over the
// two-step flag clear, so software never loses an overflow it has not seen.
// the stored interrupt enable is only kept and read back; no interrupt
// line leaves this core.
//
`timescale 1ns/1ps
module mtc_timer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic fixed_frequency_tick,
  input wire logic external_count_pin,
  output logic [7:0] count_value,
  output logic wrap_flag
);

  // whole state of the timer in one record
  // keeping every flip-flop in one struct means one reset branch and one
  // register process, so no field can be forgotten at reset
  typedef struct packed {
    logic [1:0] src;       // source select
    logic [3:0] div;       // divide select
    logic [7:0] cnt;       // live count
    logic [7:0] lim;       // wrap limit
    logic wrap;            // wrap flag
    logic armed;           // status read seen while flag set
    logic wie;             // stored enable bit, no interrupt path here
    logic halt;            // halt bit
    logic [7:0] pre;       // free-running prescaler
    logic pin_s1;          // synchroniser first stage
    logic pin_s2;          // synchroniser second stage
    logic pin_s3;          // previous synced level for edges
    logic [7:0] rdata;     // read data, valid one cycle after strobe
  } mtc_state_t;

  mtc_state_t st_q;
  mtc_state_t st_d;

  // prescaler tap select: an undefined code acts as the largest divide
  // clamping here, rather than in the register, keeps the stored code
  // readable exactly as software wrote it
  function automatic logic [3:0] mtc_div_eff(input logic [3:0] code);
    if (code > mtc_pkg::MTC_DIV_MAX) begin
      mtc_div_eff = mtc_pkg::MTC_DIV_MAX;
    end else begin
      mtc_div_eff = code;
    end
  endfunction

  // address decode used by both the write and read paths
  // a full 8-bit compare, so aliases of the four offsets read zero
  // and their writes are dropped
  function automatic logic mtc_hit(input logic [7:0] a, input logic [7:0] ofs);
    mtc_hit = (a == ofs);
  endfunction

  // combinational strobes derived from the registered state and the inputs; none of
  // them leaves the core, they only steer the next-state logic
  // and the checks at the bottom of the file
  logic src_tick;   // one pulse per selected source event
  logic cnt_en;     // one pulse per divided period
  logic [8:0] taps; // divide tick per prescaler stage
  logic wrap_evt;   // counter steps from limit to zero
  logic lim_wr;     // write to the wrap limit

  // source selection; the pin is read only after two flip-flops
  // edges are found between the second and third stage, so a pin change
  // reaches the counter three cycles later; the bus source ticks every
  // cycle and the fixed source is already a ref_clk enable
  always_comb begin
    case (mtc_pkg::mtc_src_t'(st_q.src))
      mtc_pkg::MTC_SRC_BUS: src_tick = 1'b1;
      mtc_pkg::MTC_SRC_FIXED: src_tick = fixed_frequency_tick;
      mtc_pkg::MTC_SRC_FALL: src_tick = st_q.pin_s3 & ~st_q.pin_s2;
      mtc_pkg::MTC_SRC_RISE: src_tick = ~st_q.pin_s3 & st_q.pin_s2;
      default: src_tick = 1'b0;
    endcase
  end

  // tap k fires once per 2^k source ticks; the divider never clears, so
  // a divide change needs no restart but the first period may be short
  // every tap but tap 0 on the bus source is a single-cycle pulse, so the counter itself never needs
  // a second clock and all logic stays on ref_clk
  assign taps[0] = src_tick;
  genvar gi;
  generate
    for (gi = 1; gi < 9; gi++) begin : g_tap
      assign taps[gi] = src_tick & (&st_q.pre[gi-1:0]);
    end
  endgenerate

  assign cnt_en = taps[mtc_div_eff(st_q.div)] & ~st_q.halt;
  // zero limit never matches early, so the count rolls over at 8'hff
  assign wrap_evt = cnt_en &
    ((st_q.lim == mtc_pkg::MTC_ZERO8) ? (&st_q.cnt) : (st_q.cnt == st_q.lim));
  assign lim_wr = reg_wr & mtc_hit(reg_addr, mtc_pkg::MTC_LIMIT_OFS);

  // next-state logic
  // order matters below: counting first, then register writes, then the
  // status read, then a new wrap, so later statements win; the limit write
  // is the only thing allowed to beat a wrap in the same cycle
  // read data is rebuilt every cycle, so it stands for exactly one cycle
  always_comb begin
    st_d = st_q;
    st_d.pin_s1 = external_count_pin;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;
    // prescaler counts source ticks freely, halt does not stop it
    if (src_tick) begin
      st_d.pre = st_q.pre + mtc_pkg::MTC_ONE8;
    end
    // counter step; source or divide change never touches it
    if (wrap_evt) begin
      st_d.cnt = mtc_pkg::MTC_ZERO8;
    end else if (cnt_en) begin
      st_d.cnt = st_q.cnt + mtc_pkg::MTC_ONE8;
    end
    // register writes
    // a status write always updates enable and halt; the counter reset bit
    // is a strobe and is never stored, so it reads back as zero
    // a zero in the flag position only clears when the clear was armed
    if (reg_wr) begin
      if (mtc_hit(reg_addr, mtc_pkg::MTC_STATUS_OFS)) begin
        st_d.wie = reg_wdata[mtc_pkg::MTC_WIE_BIT];
        st_d.halt = reg_wdata[mtc_pkg::MTC_HALT_BIT];
        if (reg_wdata[mtc_pkg::MTC_CRST_BIT]) begin
          st_d.cnt = mtc_pkg::MTC_ZERO8;
          st_d.wrap = 1'b0;
          st_d.armed = 1'b0;
        end else if (!reg_wdata[mtc_pkg::MTC_WRAP_BIT] && st_q.armed) begin
          st_d.wrap = 1'b0;
          st_d.armed = 1'b0;
        end
      end
      if (mtc_hit(reg_addr, mtc_pkg::MTC_CLKCFG_OFS)) begin
        // bits 7 and 6 are not stored
        st_d.src = reg_wdata[mtc_pkg::MTC_SRC_LSB +: 2];
        st_d.div = reg_wdata[mtc_pkg::MTC_DIV_LSB +: 4];
      end
      if (lim_wr) begin
        st_d.lim = reg_wdata;
        st_d.cnt = mtc_pkg::MTC_ZERO8;
        st_d.wrap = 1'b0;
        st_d.armed = 1'b0;
      end
      // writes to the count offset are ignored
    end
    // reading status while the flag is set arms the clear
    if (reg_rd && mtc_hit(reg_addr, mtc_pkg::MTC_STATUS_OFS) && st_q.wrap) begin
      st_d.armed = 1'b1;
    end
    // a new wrap wins over any clear except a limit write and restarts the two-step process
    if (wrap_evt && !lim_wr) begin
      st_d.wrap = 1'b1;
      st_d.armed = 1'b0;
    end
    // read data for the cycle after the strobe
    st_d.rdata = mtc_pkg::MTC_ZERO8;
    if (reg_rd) begin
      if (mtc_hit(reg_addr, mtc_pkg::MTC_STATUS_OFS)) begin
        st_d.rdata[mtc_pkg::MTC_WRAP_BIT] = st_q.wrap;
        st_d.rdata[mtc_pkg::MTC_WIE_BIT] = st_q.wie;
        st_d.rdata[mtc_pkg::MTC_HALT_BIT] = st_q.halt;
      end else if (mtc_hit(reg_addr, mtc_pkg::MTC_CLKCFG_OFS)) begin
        st_d.rdata[mtc_pkg::MTC_SRC_LSB +: 2] = st_q.src;
        st_d.rdata[mtc_pkg::MTC_DIV_LSB +: 4] = st_q.div;
      end else if (mtc_hit(reg_addr, mtc_pkg::MTC_COUNT_OFS)) begin
        st_d.rdata = st_q.cnt;
      end else if (mtc_hit(reg_addr, mtc_pkg::MTC_LIMIT_OFS)) begin
        st_d.rdata = st_q.lim;
      end
    end
  end

  // state register with synchronous reset
  // reset leaves the counter halted, so nothing counts until software
  // clears the halt bit; the synchroniser stages reset low, matching
  // the idle level of the pin, so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.src <= mtc_pkg::MTC_SRC_RST;
      st_q.div <= mtc_pkg::MTC_DIV_RST;
      st_q.cnt <= mtc_pkg::MTC_CNT_RST;
      st_q.lim <= mtc_pkg::MTC_LIM_RST;
      st_q.halt <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs come straight from the state register, no logic after it
  assign reg_rdata = st_q.rdata;
  assign count_value = st_q.cnt;
  assign wrap_flag = st_q.wrap;

  // checks; each one judges what the core drives, given the inputs from the bench
  // all but the reset check sleep while reset is high

  // a wrap without a competing write lands on zero with the flag up
  wrap_rolls_a: assert property (@(posedge ref_clk) disable iff (reset)
    wrap_evt && !reg_wr |=> count_value == mtc_pkg::MTC_ZERO8 && wrap_flag)
    else $error("count did not roll to zero with flag");

  // any limit write zeroes the count and drops the flag
  limit_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    lim_wr |=> count_value == mtc_pkg::MTC_ZERO8 && !wrap_flag)
    else $error("limit write did not clear count and flag");

  // halted and untouched, the count must not move
  halt_holds_a: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.halt && !reg_wr |=> $stable(count_value))
    else $error("count moved while halted");

  // zero limit: every enable steps the count by one below the top
  free_run_a: assert property (@(posedge ref_clk) disable iff (reset)
    cnt_en && st_q.lim == mtc_pkg::MTC_ZERO8 && !(&count_value) && !reg_wr
    |=> count_value == $past(count_value) + mtc_pkg::MTC_ONE8)
    else $error("free-running count did not step");

  // config reads show both fields and zero reserved bits
  cfg_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == mtc_pkg::MTC_CLKCFG_OFS |=> reg_rdata[7:6] == 2'b00
    && reg_rdata[5:0] == {$past(st_q.src), $past(st_q.div)})
    else $error("config read wrong");

  // count reads return the value live at the strobe
  count_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == mtc_pkg::MTC_COUNT_OFS |=> reg_rdata == $past(count_value))
    else $error("count read wrong");

  // undefined divide codes use the last tap
  big_div_a: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.div > mtc_pkg::MTC_DIV_MAX |-> cnt_en == (taps[8] & ~st_q.halt))
    else $error("undefined divide not treated as 256");

  // a wrap without a limit write leaves the flag set, whatever clear came with it
  flag_kept_a: assert property (@(posedge ref_clk) disable iff (reset)
    wrap_evt && !lim_wr |=> wrap_flag)
    else $error("wrap lost against clear");

  // reset values of count, source, divide, limit and halt
  reset_vals_a: assert property (@(posedge ref_clk)
    reset |=> count_value == mtc_pkg::MTC_CNT_RST && st_q.src == mtc_pkg::MTC_SRC_RST
    && st_q.div == mtc_pkg::MTC_DIV_RST && st_q.lim == mtc_pkg::MTC_LIM_RST && st_q.halt)
    else $error("reset values wrong");

  // read data stands only in the cycle after a read strobe
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
    !reg_rd |=> reg_rdata == mtc_pkg::MTC_ZERO8)
    else $error("read data not idle");

  // status reads show flag and halt, the counter reset bit reads zero
  status_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == mtc_pkg::MTC_STATUS_OFS
    |=> reg_rdata[mtc_pkg::MTC_WRAP_BIT] == $past(st_q.wrap)
    && reg_rdata[mtc_pkg::MTC_HALT_BIT] == $past(st_q.halt)
    && !reg_rdata[mtc_pkg::MTC_CRST_BIT])
    else $error("status read wrong");

  // limit reads return the stored limit
  limit_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_rd && reg_addr == mtc_pkg::MTC_LIMIT_OFS |=> reg_rdata == $past(st_q.lim))
    else $error("limit read wrong");

  // config writes store both fields as written
  cfg_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_wr && reg_addr == mtc_pkg::MTC_CLKCFG_OFS
    |=> st_q.src == $past(reg_wdata[mtc_pkg::MTC_SRC_LSB +: 2])
    && st_q.div == $past(reg_wdata[mtc_pkg::MTC_DIV_LSB +: 4]))
    else $error("config write not stored");

  // writes to the count offset never move the count
  count_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_wr && reg_addr == mtc_pkg::MTC_COUNT_OFS && !cnt_en |=> $stable(count_value))
    else $error("count write changed count");

  // status writes load the halt bit
  halt_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_wr && reg_addr == mtc_pkg::MTC_STATUS_OFS
    |=> st_q.halt == $past(reg_wdata[mtc_pkg::MTC_HALT_BIT]))
    else $error("halt bit not loaded");

  // below a nonzero limit each enable steps the count by one
  limit_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    cnt_en && st_q.lim != mtc_pkg::MTC_ZERO8 && count_value != st_q.lim && !reg_wr
    |=> count_value == $past(count_value) + mtc_pkg::MTC_ONE8)
    else $error("count did not step below limit");

  // without an enable or a write the count holds
  no_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    !cnt_en && !reg_wr |=> $stable(count_value))
    else $error("count moved without enable");

  // bus source undivided and running counts every cycle
  src_bus_a: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.src == mtc_pkg::MTC_SRC_BUS && st_q.div == mtc_pkg::MTC_DIV_RST && !st_q.halt
    |-> cnt_en)
    else $error("bus source not counting");

  // any real division yields single-cycle enables
  tick_single_a: assert property (@(posedge ref_clk) disable iff (reset)
    cnt_en && st_q.div != mtc_pkg::MTC_DIV_RST && !reg_wr |=> !cnt_en)
    else $error("divided enable longer than one cycle");

  // the flag only rises after a wrap
  flag_source_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(wrap_flag) |-> $past(wrap_evt))
    else $error("flag rose without wrap");
endmodule

// >>> testbench/tb_modulo_timer_clock_count_regs.sv
// self-checking bench for the modulo timer core: register port, rates, wrap and flag.
// assumes the core is driven by a 50 MHz clock and sees all inputs change after edges.
`timescale 1ns/1ps
module tb_modulo_timer_clock_count_regs;
  logic ref_clk = 1'b0; // bus clock
  logic reset = 1'b1; // synchronous reset
  logic [7:0] reg_addr = 8'h00; // register address
  logic [7:0] reg_wdata = 8'h00; // write data
  logic reg_wr = 1'b0; // write strobe
  logic reg_rd = 1'b0; // read strobe
  logic [7:0] reg_rdata; // read data, cycle after strobe
  logic fixed_frequency_tick = 1'b0; // fixed source, one pulse every five cycles
  logic external_count_pin = 1'b0; // pin, one rising edge every sixteen cycles
  logic [7:0] count_value; // live count
  logic wrap_flag; // wrap flag
  int n_errors = 0; // mismatches
  int checks_done = 0; // comparisons made
  int cycles = 0; // hang guard
  int ph = 0; // stimulus phase
  logic [7:0] rv; // last read value
  always #10 ref_clk = ~ref_clk;
  mtc_timer dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fixed_frequency_tick(fixed_frequency_tick), .external_count_pin(external_count_pin),
    .count_value(count_value), .wrap_flag(wrap_flag));
  // free-running sources; the pin stays well under a quarter of the bus rate
  always @(posedge ref_clk) begin
    ph <= ph + 1;
    fixed_frequency_tick <= (ph % 5 == 4);
    external_count_pin <= ph[3];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  // wait for a given count, the hang guard cuts a stuck counter short
  task automatic wait_cnt(input logic [7:0] v);
    while (count_value !== v) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  // cycles between two count steps, skipping the first possibly short period
  task automatic period(input logic [8:0] e);
    logic [7:0] v;
    int n;
    v = count_value;
    while (count_value === v) begin
      @(posedge ref_clk);
      #1;
    end
    v = count_value;
    n = 0;
    while (count_value === v) begin
      @(posedge ref_clk);
      #1;
      n = n + 1;
    end
    chk(n[8:0], e);
  endtask
  task automatic t_reset_values();
    rd(mtc_pkg::MTC_CLKCFG_OFS);
    chk({1'b0, rv}, 9'h000);
    rd(mtc_pkg::MTC_LIMIT_OFS);
    chk({1'b0, rv}, 9'h000);
    rd(mtc_pkg::MTC_STATUS_OFS);
    chk({1'b0, rv}, 9'h010);
    repeat (10) @(posedge ref_clk);
    rd(mtc_pkg::MTC_COUNT_OFS);
    chk({1'b0, rv}, 9'h000);
  endtask
  task automatic t_config_regs();
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'hff);
    rd(mtc_pkg::MTC_CLKCFG_OFS);
    chk({1'b0, rv}, 9'h03f);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h29);
    rd(mtc_pkg::MTC_CLKCFG_OFS);
    chk({1'b0, rv}, 9'h029);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h00);
    wr(mtc_pkg::MTC_COUNT_OFS, 8'h55);
    rd(mtc_pkg::MTC_COUNT_OFS);
    chk({1'b0, rv}, 9'h000);
    rd(8'h40);
    chk({1'b0, rv}, 9'h000);
  endtask
  // limit 3 on the bus clock: counts 0 to 3, wraps to 0 with the flag, then two-step clear
  task automatic t_wrap_limit();
    wr(mtc_pkg::MTC_LIMIT_OFS, 8'h03);
    wr(mtc_pkg::MTC_STATUS_OFS, 8'h00);
    wait_cnt(8'h03);
    @(posedge ref_clk);
    #1;
    chk({wrap_flag, count_value}, 9'h100);
    // halt first so no later wrap re-sets the flag during the clear
    wr(mtc_pkg::MTC_STATUS_OFS, 8'h10);
    chk({8'h00, wrap_flag}, 9'h001);
    rd(mtc_pkg::MTC_STATUS_OFS);
    chk({1'b0, rv[7], 7'h00}, 9'h080);
    wr(mtc_pkg::MTC_STATUS_OFS, 8'h10);
    chk({8'h00, wrap_flag}, 9'h000);
    wr(mtc_pkg::MTC_STATUS_OFS, 8'h00);
    wait_cnt(8'h01);
    wr(mtc_pkg::MTC_LIMIT_OFS, 8'h00);
    chk({wrap_flag, count_value}, 9'h000);
  endtask
  task automatic t_rates();
    period(9'h001);
    wait_cnt(8'h40);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h02);
    chk({8'h00, count_value >= 8'h40 && count_value < 8'h44}, 9'h001);
    period(9'h004);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h08);
    period(9'h100);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h0f);
    period(9'h100);
  endtask
  task automatic t_sources();
    logic [7:0] c;
    c = count_value;
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h10);
    chk({8'h00, (count_value - c) <= 8'h01}, 9'h001);
    period(9'h005);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h20);
    period(9'h010);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h30);
    period(9'h010);
    wr(mtc_pkg::MTC_CLKCFG_OFS, 8'h00);
    period(9'h001);
  endtask
  // limit zero lets the count pass 0xff before wrapping
  task automatic t_free_run();
    wait_cnt(8'hff);
    @(posedge ref_clk);
    #1;
    chk({wrap_flag, count_value}, 9'h100);
    wr(mtc_pkg::MTC_STATUS_OFS, 8'h10);
    c_hold();
  endtask
  task automatic c_hold();
    logic [7:0] c;
    c = count_value;
    repeat (20) @(posedge ref_clk);
    #1;
    chk({1'b0, count_value}, {1'b0, c});
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_values();
    t_config_regs();
    t_wrap_limit();
    t_rates();
    t_sources();
    t_free_run();
    finish_test();
  end
endmodule
